// ==== include/opd_regs.vh ====
// constants for the operand field decoder
`ifndef OPD_REGS_VH
`define OPD_REGS_VH

// operand format codes, given with the opcode byte
`define OPD_FMT_NULL 4'h0
`define OPD_FMT_DEBUG 4'h1
`define OPD_FMT_DIRECT 4'h2
`define OPD_FMT_EXT 4'h3
`define OPD_FMT_IMM8 4'h4
`define OPD_FMT_IMM16 4'h5
`define OPD_FMT_MASK 4'h6
`define OPD_FMT_REL8 4'h7
`define OPD_FMT_REL16 4'h8
`define OPD_FMT_INDEXED 4'h9
`define OPD_FMT_LOOP 4'ha
`define OPD_FMT_PAGE 4'hb
`define OPD_FMT_TRAP 4'hc
`define OPD_FMT_SNEVER 4'hd
`define OPD_FMT_LNEVER 4'he

// decoder states
`define OPD_ST_IDLE 2'h0
`define OPD_ST_OPND 2'h1
`define OPD_ST_FIN 2'h2

// indexed form codes reported on idx_form
`define OPD_IDX_NONE 3'h0
`define OPD_IDX_OFF5 3'h1
`define OPD_IDX_OFF9 3'h2
`define OPD_IDX_OFF16 3'h3
`define OPD_IDX_AUTO 3'h4
`define OPD_IDX_ACC 3'h5

// indexed postbyte field positions
`define OPD_PB_KIND_BIT 5
`define OPD_PB_POST_BIT 4
`define OPD_PB_DEC_BIT 3
`define OPD_PB_LONG_BIT 2
`define OPD_PB_WIDE_BIT 1
`define OPD_PB_SIGN_BIT 0
`define OPD_PB_LONG_TAG 3'h7

// base register select codes
`define OPD_REG_PC 2'h3

// sign bit of the 9-bit loop offset inside the loop postbyte
`define OPD_LOOP_SIGN_BIT 4

// legal trap number ranges
`define OPD_TRAP_LO_MIN 8'h30
`define OPD_TRAP_LO_MAX 8'h39
`define OPD_TRAP_HI_MIN 8'h40

// reset values
`define OPD_RST_WORD 16'h0000
`define OPD_RST_BYTE 8'h00

`endif

// ==== hdl/opd_decode.v ====
// operand field decoder: collects operand bytes after an opcode and decodes them
//
// Notes on behaviour
// RQ1: debug-entry opcode enters background debug state only when enabled; else just continues.
// RQ2: short and long branch-never consume their offset bytes but never branch.
// RQ3: null operation only advances the program counter; nothing else changes.
// RQ4: direct operand byte is the low address byte; upper byte forced to zero.
// RQ5: bit-manipulation mask byte: each set bit marks an operand bit affected.
// RQ6: short branch offset is signed byte, added to address after the offset.
// RQ7: long branch offset is 16 bits, high byte first then low byte.
// RQ8: 16-bit index offset high byte first; 9-bit offset low eight bits follow.
// RQ9: 16-bit immediate is high byte first, low byte second.
// RQ10: extended address is high byte first and spans the whole 64K space.
// RQ11: every indexed form starts with one 8-bit postbyte; its value sets how many offset bytes follow.
// RQ12: auto increment and decrement amounts run from 1 to 8 only.
// RQ13: short indexed offset is 5-bit signed, sign-extended over -16 to +15.
// RQ14: 9-bit indexed offset covers -256 to +255.
// RQ15: loop offset sign comes from the loop postbyte, low eight bits follow.
// RQ16: PC-relative indexed base is the address after the instruction's last byte.
// RQ17: long relative target is the 16-bit offset plus next instruction address.
// RQ18: far-call page operand is up to 8 bits; fewer may be kept.
// RQ19: software trap number must lie in 30..39 or 40..ff hex.
`timescale 1ns/100ps
`include "opd_regs.vh"

module opd_decode #(
  parameter PAGE_W = 8
) (
  // clock and reset
  core_clk,
  sys_rst,
  // byte stream from instruction memory
  in_valid,
  in_ready,
  in_first,
  in_byte,
  in_format,
  in_addr,
  // debug control
  debug_enable,
  // decoded result
  dec_done,
  dec_format,
  next_addr,
  oper_addr,
  imm_value,
  bit_mask,
  offset,
  branch_target,
  branch_take,
  enter_debug,
  idx_form,
  idx_reg,
  idx_amount,
  idx_dec,
  idx_post,
  idx_base,
  loop_postbyte,
  page_value,
  trap_number,
  trap_legal
);
  input core_clk;
  input sys_rst;
  input in_valid;
  output in_ready;
  input in_first;
  input [7:0] in_byte;
  input [3:0] in_format;
  input [15:0] in_addr;
  input debug_enable;
  output dec_done;
  output [3:0] dec_format;
  output [15:0] next_addr;
  output [15:0] oper_addr;
  output [15:0] imm_value;
  output [7:0] bit_mask;
  output [15:0] offset;
  output [15:0] branch_target;
  output branch_take;
  output enter_debug;
  output [2:0] idx_form;
  output [1:0] idx_reg;
  output [3:0] idx_amount;
  output idx_dec;
  output idx_post;
  output [15:0] idx_base;
  output [7:0] loop_postbyte;
  output [PAGE_W-1:0] page_value;
  output [7:0] trap_number;
  output trap_legal;

  wire core_clk;
  wire sys_rst;
  wire in_valid;
  wire in_first;
  wire [7:0] in_byte;
  wire [3:0] in_format;
  wire [15:0] in_addr;
  wire debug_enable;

  // operand bytes that follow each format's opcode, counting only the postbyte for indexed
  function [1:0] fmt_len;
    input [3:0] f;
    begin
      case (f)
        `OPD_FMT_DIRECT, `OPD_FMT_IMM8, `OPD_FMT_MASK, `OPD_FMT_REL8,
        `OPD_FMT_INDEXED, `OPD_FMT_TRAP, `OPD_FMT_SNEVER: fmt_len = 2'd1;
        `OPD_FMT_EXT, `OPD_FMT_IMM16, `OPD_FMT_REL16, `OPD_FMT_LOOP,
        `OPD_FMT_LNEVER: fmt_len = 2'd2;
        `OPD_FMT_PAGE: fmt_len = 2'd3;
        default: fmt_len = 2'd0;
      endcase
    end
  endfunction

  // bytes that follow an indexed postbyte
  function [1:0] idx_extra;
    input [7:0] pbyte;
    begin
      if (pbyte[7:5] == `OPD_PB_LONG_TAG && !pbyte[`OPD_PB_LONG_BIT]) begin
        idx_extra = pbyte[`OPD_PB_WIDE_BIT] ? 2'd2 : 2'd1; // [RQ8]
      end else begin
        idx_extra = 2'd0;
      end
    end
  endfunction

  function [15:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{8{v[7]}}, v};
    end
  endfunction

  function [15:0] sext9;
    input s;
    input [7:0] v;
    begin
      sext9 = {{8{s}}, v};
    end
  endfunction

  reg [1:0] state_reg;
  reg [3:0] fmt_reg;
  reg [15:0] addr_reg;
  reg [2:0] len_reg;
  reg [1:0] need_reg;
  reg [1:0] cnt_reg;
  reg [7:0] b0_reg;
  reg [7:0] b1_reg;
  reg [7:0] b2_reg;

  reg done_reg;
  reg [3:0] dfmt_reg;
  reg [15:0] next_reg;
  reg [15:0] ea_reg;
  reg [15:0] imm_reg;
  reg [7:0] mask_reg;
  reg [15:0] off_reg;
  reg [15:0] tgt_reg;
  reg take_reg;
  reg dbg_reg;
  reg [2:0] form_reg;
  reg [1:0] ireg_reg;
  reg [3:0] amt_reg;
  reg dec_reg;
  reg post_reg;
  reg [15:0] base_reg;
  reg [7:0] lpb_reg;
  reg [PAGE_W-1:0] page_reg;
  reg [7:0] trap_reg;
  reg trap_ok_reg;

  // no new byte while results are being formed
  assign in_ready = (state_reg != `OPD_ST_FIN);

  wire take_byte = in_valid && in_ready;
  wire [15:0] nxt = addr_reg + {13'h0000, len_reg};

  // byte collection
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= `OPD_ST_IDLE;
      fmt_reg <= `OPD_FMT_NULL;
      addr_reg <= `OPD_RST_WORD;
      len_reg <= 3'h0;
      need_reg <= 2'h0;
      cnt_reg <= 2'h0;
      b0_reg <= `OPD_RST_BYTE;
      b1_reg <= `OPD_RST_BYTE;
      b2_reg <= `OPD_RST_BYTE;
    end else begin
      case (state_reg)
        `OPD_ST_IDLE: begin
          if (take_byte && in_first) begin
            fmt_reg <= in_format;
            addr_reg <= in_addr;
            len_reg <= 3'h1;
            need_reg <= fmt_len(in_format);
            cnt_reg <= 2'h0;
            state_reg <= (fmt_len(in_format) == 2'd0) ? `OPD_ST_FIN : `OPD_ST_OPND;
          end
        end
        `OPD_ST_OPND: begin
          if (take_byte) begin
            case (cnt_reg)
              2'd0: b0_reg <= in_byte;
              2'd1: b1_reg <= in_byte;
              default: b2_reg <= in_byte;
            endcase
            cnt_reg <= cnt_reg + 2'd1;
            len_reg <= len_reg + 3'h1;
            // the postbyte alone tells how many offset bytes follow
            if (fmt_reg == `OPD_FMT_INDEXED && cnt_reg == 2'd0) begin
              need_reg <= idx_extra(in_byte); // [RQ11]
              if (idx_extra(in_byte) == 2'd0) begin
                state_reg <= `OPD_ST_FIN;
              end
            end else begin
              need_reg <= need_reg - 2'd1;
              if (need_reg == 2'd1) begin
                state_reg <= `OPD_ST_FIN;
              end
            end
          end
        end
        `OPD_ST_FIN: begin
          state_reg <= `OPD_ST_IDLE;
        end
        default: begin
          state_reg <= `OPD_ST_IDLE;
        end
      endcase
    end
  end

  // result formation; fields not used by a format keep their last value, except branch_take and enter_debug, which drop to zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      dfmt_reg <= `OPD_FMT_NULL;
      next_reg <= `OPD_RST_WORD;
      ea_reg <= `OPD_RST_WORD;
      imm_reg <= `OPD_RST_WORD;
      mask_reg <= `OPD_RST_BYTE;
      off_reg <= `OPD_RST_WORD;
      tgt_reg <= `OPD_RST_WORD;
      take_reg <= 1'b0;
      dbg_reg <= 1'b0;
      form_reg <= `OPD_IDX_NONE;
      ireg_reg <= 2'h0;
      amt_reg <= 4'h0;
      dec_reg <= 1'b0;
      post_reg <= 1'b0;
      base_reg <= `OPD_RST_WORD;
      lpb_reg <= `OPD_RST_BYTE;
      page_reg <= {PAGE_W{1'b0}};
      trap_reg <= `OPD_RST_BYTE;
      trap_ok_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == `OPD_ST_FIN);
      take_reg <= 1'b0;
      dbg_reg <= 1'b0;
      if (state_reg == `OPD_ST_FIN) begin
        dfmt_reg <= fmt_reg;
        next_reg <= nxt; // [RQ3]
        case (fmt_reg)
          `OPD_FMT_DEBUG: begin
            // without debug enabled this behaves as a plain step
            dbg_reg <= debug_enable; // [RQ1]
          end
          `OPD_FMT_DIRECT: begin
            ea_reg <= {8'h00, b0_reg}; // [RQ4]
          end
          `OPD_FMT_EXT: begin
            ea_reg <= {b0_reg, b1_reg}; // [RQ10]
          end
          `OPD_FMT_IMM8: begin
            imm_reg <= {8'h00, b0_reg};
          end
          `OPD_FMT_IMM16: begin
            imm_reg <= {b0_reg, b1_reg}; // [RQ9]
          end
          `OPD_FMT_MASK: begin
            mask_reg <= b0_reg; // [RQ5]
          end
          `OPD_FMT_REL8: begin
            off_reg <= sext8(b0_reg);
            tgt_reg <= nxt + sext8(b0_reg); // [RQ6]
            take_reg <= 1'b1;
          end
          `OPD_FMT_REL16: begin
            off_reg <= {b0_reg, b1_reg}; // [RQ7]
            tgt_reg <= nxt + {b0_reg, b1_reg}; // [RQ17]
            take_reg <= 1'b1;
          end
          `OPD_FMT_SNEVER: begin
            // offset kept for inspection, flow stays sequential
            off_reg <= sext8(b0_reg);
            tgt_reg <= nxt; // [RQ2]
          end
          `OPD_FMT_LNEVER: begin
            off_reg <= {b0_reg, b1_reg};
            tgt_reg <= nxt; // [RQ2]
          end
          `OPD_FMT_LOOP: begin
            lpb_reg <= b0_reg;
            off_reg <= sext9(b0_reg[`OPD_LOOP_SIGN_BIT], b1_reg); // [RQ15]
            tgt_reg <= nxt + sext9(b0_reg[`OPD_LOOP_SIGN_BIT], b1_reg);
          end
          `OPD_FMT_PAGE: begin
            ea_reg <= {b0_reg, b1_reg};
            // narrower page registers simply drop the upper bits
            page_reg <= b2_reg[PAGE_W-1:0]; // [RQ18]
          end
          `OPD_FMT_TRAP: begin
            trap_reg <= b0_reg;
            trap_ok_reg <= (b0_reg >= `OPD_TRAP_LO_MIN && b0_reg <= `OPD_TRAP_LO_MAX) ||
                           (b0_reg >= `OPD_TRAP_HI_MIN); // [RQ19]
          end
          `OPD_FMT_INDEXED: begin
            base_reg <= nxt; // [RQ16]
            amt_reg <= 4'h0;
            dec_reg <= 1'b0;
            post_reg <= 1'b0;
            if (!b0_reg[`OPD_PB_KIND_BIT]) begin
              form_reg <= `OPD_IDX_OFF5;
              ireg_reg <= b0_reg[7:6];
              off_reg <= {{11{b0_reg[4]}}, b0_reg[4:0]}; // [RQ13]
            end else if (b0_reg[7:5] == `OPD_PB_LONG_TAG) begin
              ireg_reg <= b0_reg[4:3];
              if (b0_reg[`OPD_PB_LONG_BIT]) begin
                form_reg <= `OPD_IDX_ACC;
              end else if (!b0_reg[`OPD_PB_WIDE_BIT]) begin
                form_reg <= `OPD_IDX_OFF9;
                off_reg <= sext9(b0_reg[`OPD_PB_SIGN_BIT], b1_reg); // [RQ14]
              end else begin
                form_reg <= `OPD_IDX_OFF16;
                off_reg <= {b1_reg, b2_reg}; // [RQ8]
              end
            end else begin
              // auto adjust: low nibble is 0..7 for +1..+8, or -1..-8 in two's complement
              form_reg <= `OPD_IDX_AUTO;
              ireg_reg <= b0_reg[7:6];
              dec_reg <= b0_reg[`OPD_PB_DEC_BIT];
              post_reg <= b0_reg[`OPD_PB_POST_BIT];
              amt_reg <= b0_reg[`OPD_PB_DEC_BIT] ? (4'h0 - b0_reg[3:0])
                                                  : (b0_reg[3:0] + 4'h1); // [RQ12]
            end
          end
          default: begin
            // null operation: only next_addr moves
          end
        endcase
      end
    end
  end

  assign dec_done = done_reg;
  assign dec_format = dfmt_reg;
  assign next_addr = next_reg;
  assign oper_addr = ea_reg;
  assign imm_value = imm_reg;
  assign bit_mask = mask_reg;
  assign offset = off_reg;
  assign branch_target = tgt_reg;
  assign branch_take = take_reg;
  assign enter_debug = dbg_reg;
  assign idx_form = form_reg;
  assign idx_reg = ireg_reg;
  assign idx_amount = amt_reg;
  assign idx_dec = dec_reg;
  assign idx_post = post_reg;
  assign idx_base = base_reg;
  assign loop_postbyte = lpb_reg;
  assign page_value = page_reg;
  assign trap_number = trap_reg;
  assign trap_legal = trap_ok_reg;

endmodule

// ==== tb/opd_decode_properties.sv ====
// port-level checks of the operand field decoder
`timescale 1ns/100ps
`include "opd_regs.vh"
module opd_decode_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // stream and control
  input wire logic in_ready,
  input wire logic debug_enable,
  // results
  input wire logic dec_done,
  input wire logic [3:0] dec_format,
  input wire logic [15:0] next_addr,
  input wire logic [15:0] oper_addr,
  input wire logic [15:0] offset,
  input wire logic [15:0] branch_target,
  input wire logic branch_take,
  input wire logic enter_debug,
  input wire logic [2:0] idx_form,
  input wire logic [3:0] idx_amount,
  input wire logic [15:0] idx_base,
  input wire logic [7:0] trap_number,
  input wire logic trap_legal
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_fin;
    !in_ready;
  endsequence
  sequence s_answer;
    dec_done ##1 !dec_done;
  endsequence
  wire ix = dec_done && dec_format == `OPD_FMT_INDEXED;
  AST_ANSWER: assert property (s_fin |=> s_answer)
    else $error("done does not follow the final cycle");
  AST_DEBUG: assert property (dec_done && dec_format == `OPD_FMT_DEBUG |->
    enter_debug == $past(debug_enable)) else $error("debug entry wrong");
  AST_NEVER: assert property (dec_done && (dec_format == `OPD_FMT_SNEVER ||
    dec_format == `OPD_FMT_LNEVER) |-> !branch_take && branch_target == next_addr)
    else $error("branch never changed flow");
  AST_NULL: assert property (dec_done && dec_format == `OPD_FMT_NULL |->
    $stable(oper_addr) && $stable(offset)) else $error("null changed fields");
  AST_DIRECT: assert property (dec_done && dec_format == `OPD_FMT_DIRECT |->
    oper_addr[15:8] == 8'h00) else $error("direct upper byte not zero");
  AST_REL: assert property (dec_done && (dec_format == `OPD_FMT_REL8 ||
    dec_format == `OPD_FMT_REL16) |-> branch_take && branch_target == next_addr + offset)
    else $error("relative target wrong");
  AST_LOOP: assert property (dec_done && dec_format == `OPD_FMT_LOOP |->
    offset[15:9] == {7{offset[8]}} && !branch_take) else $error("loop offset wrong");
  AST_OFF5: assert property (ix && idx_form == `OPD_IDX_OFF5 |->
    offset[15:4] == {12{offset[4]}}) else $error("short offset not extended");
  AST_OFF9: assert property (ix && idx_form == `OPD_IDX_OFF9 |->
    offset[15:8] == {8{offset[8]}}) else $error("9-bit offset not extended");
  AST_AUTO: assert property (ix && idx_form == `OPD_IDX_AUTO |->
    idx_amount >= 4'h1 && idx_amount <= 4'h8) else $error("adjust amount out of range");
  AST_PCBASE: assert property (ix |-> idx_base == next_addr)
    else $error("relative base wrong");
  AST_TRAP: assert property (dec_done && dec_format == `OPD_FMT_TRAP |->
    trap_legal == (trap_number >= 8'h30 && (trap_number <= 8'h39 || trap_number >= 8'h40)))
    else $error("trap legality wrong");
endmodule

// ==== tb/opd_imem_model.sv ====
// instruction memory model: streams one opcode and its operand bytes
`timescale 1ns/100ps
module opd_imem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request from the bench; byte 0 is the opcode in bytes[31:24]
  input wire logic start,
  input wire logic slow,
  input wire logic [2:0] n_bytes,
  input wire logic [31:0] bytes,
  input wire logic [3:0] fmt,
  input wire logic [15:0] addr,
  // byte stream
  input wire logic in_ready,
  output logic in_valid,
  output logic in_first,
  output logic [7:0] in_byte,
  output logic [3:0] in_format,
  output logic [15:0] in_addr,
  output logic busy
);
  logic [2:0] idx;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      {in_valid, in_first, busy, idx, in_byte, in_format, in_addr} <= '0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      in_valid <= 1'b1;
      in_first <= 1'b1;
      idx <= 3'h1;
      in_byte <= bytes[31:24];
      in_format <= fmt;
      in_addr <= addr;
    end else if (busy && in_valid && in_ready) begin
      in_first <= 1'b0;
      if (idx == n_bytes || slow) begin
        // a released line shows the inverse, not a stale byte
        in_valid <= 1'b0;
        in_byte <= ~in_byte;
        busy <= idx != n_bytes;
      end else begin
        in_byte <= bytes[31-8*idx -: 8];
        idx <= idx + 3'h1;
      end
    end else if (busy && !in_valid) begin
      in_valid <= 1'b1;
      in_byte <= bytes[31-8*idx -: 8];
      idx <= idx + 3'h1;
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the operand field decoder
`timescale 1ns/100ps
`include "opd_regs.vh"
module tb;
  logic core_clk, sys_rst, debug_enable, start, slow;
  logic [2:0] n_bytes;
  logic [31:0] bytes;
  logic [3:0] fmt;
  logic [15:0] addr;
  wire in_valid, in_ready, in_first, busy, dec_done, branch_take, enter_debug;
  wire idx_dec, idx_post, trap_legal;
  wire [7:0] in_byte, bit_mask, loop_postbyte, page_value, trap_number;
  wire [3:0] in_format, dec_format, idx_amount;
  wire [15:0] in_addr, next_addr, oper_addr, imm_value, offset, branch_target, idx_base;
  wire [2:0] idx_form;
  wire [1:0] idx_reg;
  int n_mismatch = 0;
  int compares = 0;
  opd_imem_model opd_imem_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .start(start), .slow(slow), .n_bytes(n_bytes), .bytes(bytes), .fmt(fmt), .addr(addr),
    .in_ready(in_ready), .in_valid(in_valid), .in_first(in_first), .in_byte(in_byte),
    .in_format(in_format), .in_addr(in_addr), .busy(busy));
  opd_decode opd_decode_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .in_valid(in_valid), .in_ready(in_ready), .in_first(in_first), .in_byte(in_byte),
    .in_format(in_format), .in_addr(in_addr), .debug_enable(debug_enable),
    .dec_done(dec_done), .dec_format(dec_format), .next_addr(next_addr),
    .oper_addr(oper_addr), .imm_value(imm_value), .bit_mask(bit_mask), .offset(offset),
    .branch_target(branch_target), .branch_take(branch_take), .enter_debug(enter_debug),
    .idx_form(idx_form), .idx_reg(idx_reg), .idx_amount(idx_amount), .idx_dec(idx_dec),
    .idx_post(idx_post), .idx_base(idx_base), .loop_postbyte(loop_postbyte),
    .page_value(page_value), .trap_number(trap_number), .trap_legal(trap_legal));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one instruction; returns just after the edge that raised dec_done
  task automatic run(input logic [3:0] f, input logic [15:0] a, input logic [2:0] n,
                     input logic [31:0] b, input logic s);
    int i;
    @(posedge core_clk);
    fmt <= f;
    addr <= a;
    n_bytes <= n;
    bytes <= b;
    slow <= s;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (i = 0; i < 30 && dec_done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check("done", dec_done, 16'h0001);
    check("dec_format", dec_format, {12'h000, f});
    check("in_ready", in_ready, 16'h0001);
  endtask
  task automatic t_debug_null();
    for (int e = 0; e < 2; e++) begin
      @(posedge core_clk);
      debug_enable <= e[0];
      run(`OPD_FMT_DEBUG, 16'h2000, 3'h1, 32'h0, 1'b0);
      check("enter_debug", enter_debug, e[15:0]);
    end
    run(`OPD_FMT_NULL, 16'h1000, 3'h1, 32'h0, 1'b1);
    check("next_addr", next_addr, 16'h1001);
    check("enter_debug", enter_debug, 16'h0);
  endtask
  task automatic t_operands();
    run(`OPD_FMT_DIRECT, 16'h1100, 3'h2, 32'h005a0000, 1'b1);
    check("oper_addr", oper_addr, 16'h005a);
    run(`OPD_FMT_MASK, 16'h1100, 3'h2, 32'h00a50000, 1'b0);
    check("bit_mask", bit_mask, 16'h00a5);
    run(`OPD_FMT_IMM8, 16'h1100, 3'h2, 32'h00c30000, 1'b0);
    check("imm_value", imm_value, 16'h00c3);
    run(`OPD_FMT_EXT, 16'h1100, 3'h3, 32'h00ff0100, 1'b0);
    check("oper_addr", oper_addr, 16'hff01);
    run(`OPD_FMT_IMM16, 16'h1100, 3'h3, 32'h00abcd00, 1'b1);
    check("imm_value", imm_value, 16'habcd);
    run(`OPD_FMT_PAGE, 16'h1100, 3'h4, 32'h00123405, 1'b0);
    check("page_value", page_value, 16'h0005);
    check("next_addr", next_addr, 16'h1104);
  endtask
  task automatic t_branch();
    run(`OPD_FMT_REL8, 16'h2000, 3'h2, 32'h00800000, 1'b1);
    check("target", branch_target, 16'h2002 - 16'h0080);
    run(`OPD_FMT_REL8, 16'h2000, 3'h2, 32'h007f0000, 1'b0);
    check("target", branch_target, 16'h2002 + 16'h007f);
    run(`OPD_FMT_REL16, 16'hfffe, 3'h3, 32'h00fffe00, 1'b0);
    check("target", branch_target, 16'h0001 - 16'h0002);
    run(`OPD_FMT_SNEVER, 16'h2000, 3'h2, 32'h00100000, 1'b0);
    check("take", branch_take, 16'h0);
    check("target", branch_target, 16'h2002);
    run(`OPD_FMT_LNEVER, 16'h2000, 3'h3, 32'h00123400, 1'b1);
    check("offset", offset, 16'h1234);
    check("target", branch_target, 16'h2003);
  endtask
  task automatic t_indexed();
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h4, 32'h00fa8001, 1'b1);
    check("offset", offset, 16'h8001);
    check("idx_form", idx_form, `OPD_IDX_OFF16);
    check("idx_reg", idx_reg, {14'h0000, `OPD_REG_PC});
    check("idx_base", idx_base, 16'h3004);
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h3, 32'h00e10000, 1'b0);
    check("offset", offset, 16'hff00);
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h2, 32'h00280000, 1'b0);
    check("idx_amount", idx_amount, 16'h0008);
    check("idx_dec", idx_dec, 16'h0001);
    check("idx_post", idx_post, 16'h0000);
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h2, 32'h00330000, 1'b1);
    check("idx_amount", idx_amount, 16'h0004);
    check("idx_dec", idx_dec, 16'h0000);
    check("idx_post", idx_post, 16'h0001);
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h2, 32'h00100000, 1'b0);
    check("next_addr", next_addr, 16'h3002);
    check("idx_form", idx_form, `OPD_IDX_OFF5);
    check("offset", offset, 16'hfff0);
    run(`OPD_FMT_INDEXED, 16'h3000, 3'h2, 32'h00e40000, 1'b0);
    check("idx_form", idx_form, `OPD_IDX_ACC);
    check("next_addr", next_addr, 16'h3002);
  endtask
  task automatic t_loop_trap();
    logic [7:0] trap_codes [6] = '{8'h2f, 8'h30, 8'h39, 8'h3a, 8'h40, 8'hff};
    run(`OPD_FMT_LOOP, 16'h4000, 3'h3, 32'h00100000, 1'b1);
    check("offset", offset, 16'hff00);
    check("loop_postbyte", loop_postbyte, 16'h0010);
    check("target", branch_target, 16'h4003 + 16'hff00);
    foreach (trap_codes[k]) begin
      run(`OPD_FMT_TRAP, 16'h5000, 3'h2, {8'h00, trap_codes[k], 16'h0}, 1'b0);
      check("trap_number", trap_number, {8'h00, trap_codes[k]});
      check("trap_legal", trap_legal, {15'h0, k != 0 && k != 3});
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    debug_enable = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    n_bytes = 3'h0;
    bytes = 32'h0;
    fmt = 4'h0;
    addr = 16'h0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_debug_null();
    t_operands();
    t_branch();
    t_indexed();
    t_loop_trap();
    results();
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule
bind opd_decode opd_decode_properties opd_decode_properties_inst (.core_clk(core_clk),
  .sys_rst(sys_rst), .in_ready(in_ready), .debug_enable(debug_enable),
  .dec_done(dec_done), .dec_format(dec_format), .next_addr(next_addr),
  .oper_addr(oper_addr), .offset(offset), .branch_target(branch_target),
  .branch_take(branch_take), .enter_debug(enter_debug), .idx_form(idx_form),
  .idx_amount(idx_amount), .idx_base(idx_base), .trap_number(trap_number),
  .trap_legal(trap_legal));
